// File: hdl/ddid_pkg.sv
package ddid_pkg;
    // terminal count and function code width
    localparam int unsigned N_TERM = 5;
    localparam int unsigned CODE_W = 6;
    // function selection codes
    localparam logic [5:0] C_NONE        = 6'h00;
    localparam logic [5:0] C_RESET       = 6'h01;
    localparam logic [5:0] C_COAST_LO    = 6'h02;
    localparam logic [5:0] C_CLR_FREE_LO = 6'h03;
    localparam logic [5:0] C_QSTOP_LO    = 6'h04;
    localparam logic [5:0] C_DCB_LO      = 6'h05;
    localparam logic [5:0] C_STOP_LO     = 6'h06;
    localparam logic [5:0] C_START       = 6'h07;
    localparam logic [5:0] C_LATCH       = 6'h08;
    localparam logic [5:0] C_REV         = 6'h09;
    localparam logic [5:0] C_REV_START   = 6'h0a;
    localparam logic [5:0] C_CW          = 6'h0b;
    localparam logic [5:0] C_CCW         = 6'h0c;
    localparam logic [5:0] C_INCH        = 6'h0d;
    localparam logic [5:0] C_FRZ_REF     = 6'h0e;
    localparam logic [5:0] C_FRZ_OUT     = 6'h0f;
    localparam logic [5:0] C_UP          = 6'h10;
    localparam logic [5:0] C_DOWN        = 6'h11;
    localparam logic [5:0] C_CATCH_UP    = 6'h13;
    localparam logic [5:0] C_PRESET_ON   = 6'h18;
    localparam logic [5:0] C_PRE_STOP_LO = 6'h1a;
    localparam logic [5:0] C_PRE_SS      = 6'h1b;
    localparam logic [5:0] C_PULSE_REF   = 6'h1c;
    localparam logic [5:0] C_PULSE_FB    = 6'h1d;
    localparam logic [5:0] C_PULSE_IN    = 6'h1e;
    localparam logic [5:0] C_SETUP_LSB   = 6'h1f;
    localparam logic [5:0] C_RST_START   = 6'h21;
    localparam logic [5:0] C_ENC_FIRST   = 6'h22;
    localparam logic [5:0] C_ENC_LAST    = 6'h24;
    // reset codes, terminal 0 in the low slot
    localparam logic [4:0][5:0] CODE_RST =
        {C_NONE, C_INCH, C_CLR_FREE_LO, C_REV, C_START};
    // register byte offsets
    localparam int unsigned ADDR_W   = 8;
    localparam logic [7:0]  REG_CODE0 = 8'h00;
    localparam logic [7:0]  REG_CODE4 = 8'h10;
    localparam logic [7:0]  REG_CFG   = 8'h14;
    localparam logic [7:0]  REG_STAT  = 8'h18;
    localparam logic [7:0]  REG_ADJ   = 8'h1c;
    // config bits
    localparam int unsigned CFG_PULSE_OUT = 0;
    localparam int unsigned CFG_CLOSED    = 1;
    localparam int unsigned CFG_DC_TIME   = 2;
    localparam int unsigned CFG_DC_VOLT   = 3;
    localparam logic [3:0]  CFG_RST       = 4'h0;
    // status bits
    localparam int unsigned STAT_REJECT   = 0;
    localparam int unsigned STAT_CONFLICT = 1;
    localparam int unsigned STAT_LATCH    = 2;
    localparam int unsigned STAT_RUN      = 3;
    localparam int unsigned STAT_REV      = 4;
    localparam int unsigned STAT_TERM     = 8;
    // timing
    localparam int unsigned CLK_HZ        = 50000000;
    localparam int unsigned PULSE_MIN_MS  = 14;
    localparam int unsigned PULSE_MIN_CYC =
        (PULSE_MIN_MS * (CLK_HZ / 1000));
    localparam int unsigned CNT_W         = 20;
    localparam int unsigned ADJ_W         = 16;

    typedef enum logic [1:0] {UD_IDLE, UD_HIGH, UD_LOW} ddid_ud_type;

    typedef struct packed {
        logic run;
        logic reverse;
        logic coast;
        logic quick_stop;
        logic dc_brake;
        logic ramp_stop;
        logic inch;
        logic freeze_ref;
        logic freeze_out;
        logic ramp2;
        logic step_up;
        logic step_down;
        logic step_is_ref;
        logic alarm_clear;
    } ddid_cmd_type;

    typedef struct packed {
        logic [4:0]       sync1;
        logic [4:0]       sync2;
        logic [4:0]       prev;
        logic [4:0][5:0]  codes;
        logic [3:0]       cfg;
        logic             reject;
        logic             conflict;
        logic             latch;
        logic [19:0]      lat_cnt;
        ddid_ud_type      ud;
        logic [19:0]      ud_cnt;
        logic             ud_dn;
        logic [15:0]      adj;
        ddid_cmd_type     cmd;
        logic [31:0]      prdata;
    } ddid_state_type;
endpackage : ddid_pkg

// File: hdl/ddid_top.sv
// Overview of operation
// - each of five terminals has its own function code deciding its use
// - reset codes: start, reversing, clear-freewheel, inching, none
// - pulse, encoder and precise codes only on their allowed terminals
// - pulse codes refused on terminal 3 while digital output is pulse
// - code none produces no command at all
// - reset code clears alarm on rising edge, never a trip-locked one
// - coast inverse low turns output stage off at once
// - clear-freewheel low coasts; alarm clear on its falling edge
// - quick-stop inverse low requests quick-stop ramp down
// - dc brake low brakes only when brake time and voltage nonzero
// - stop inverse low ramps motor to zero on selected ramp
// - start code runs while high, stops while low
// - latched start: high 14 ms latches run; stop inverse clears it
// - reversing high inverts direction, no start, off in closed loop
// - reverse-and-start runs reversed; no other start; off closed loop
// - clockwise start runs forward only, anticlockwise reverse only
// - inching overrides frequency without start, not during coast, quick-stop or dc brake
// - freeze reference holds reference through stop; only up/down move
// - freeze output holds frequency; only coast/quick/dc brake stop it
// - speed up/down act only while a freeze function terminal is high
// - up/down frequency changes use the second ramp under freeze output only
// - 14 ms high then 14 ms low gives one step; both high is down
`timescale 1ns/10ps
`default_nettype none
module ddid_top
    import ddid_pkg::*;
#(
    parameter int unsigned MIN_PULSE_CYCLES = PULSE_MIN_CYC
) (
    input  wire logic               clk_in,
    input  wire logic               rstn_in,
    input  wire logic               psel_in,
    input  wire logic               penable_in,
    input  wire logic               pwrite_in,
    input  wire logic [ADDR_W-1:0]  paddr_in,
    input  wire logic [31:0]        pwdata_in,
    output logic [31:0]             prdata_out,
    output logic                    pready_out,
    output logic                    pslverr_out,
    input  wire logic [N_TERM-1:0]  term_in,
    input  wire logic               alarm_pending_in,
    input  wire logic               alarm_locked_in,
    output ddid_cmd_type            cmd_out,
    output logic [ADJ_W-1:0]        ref_adjust_out
);

    ddid_state_type s_r;
    ddid_state_type s_nxt;

    // terminals whose code equals c; never called with code none
    function automatic logic [4:0] sel(input logic [4:0][5:0] codes,
                                       input logic [5:0] c);
        logic [4:0] m;
        m = 5'h00;
        for (int i = 0; i < N_TERM; i++) begin
            m[i] = (codes[i] == c);
        end
        return m;
    endfunction : sel

    // whether code c may be stored for terminal idx
    function automatic logic legal(input int unsigned idx,
                                   input logic [5:0] c,
                                   input logic pulse_out);
        logic ok;
        ok = 1'b0;
        if (c <= C_DOWN) begin
            ok = 1'b1;
        end else if (c >= C_CATCH_UP && c <= C_PRESET_ON) begin
            ok = 1'b1;
        end else if (c >= C_SETUP_LSB && c <= C_RST_START) begin
            ok = 1'b1;
        end else if (c == C_PRE_STOP_LO || c == C_PRE_SS) begin
            ok = (idx < 2);
        end else if (c == C_PULSE_REF || c == C_PULSE_FB) begin
            ok = (idx == 4) || (idx == 3 && !pulse_out);
        end else if (c == C_PULSE_IN) begin
            ok = (idx == 4);
        end else if (c >= C_ENC_FIRST && c <= C_ENC_LAST) begin
            ok = (idx >= 3);
        end
        return ok;
    endfunction : legal

    // mapped, word aligned register address
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= REG_ADJ);
    endfunction : mapped

    logic [4:0] lvl;
    logic [4:0] rise;
    logic [4:0] fall;
    logic       coast;
    logic       quick;
    logic       dc_req;
    logic       dc;
    logic       stop_lo;
    logic       start_hi;
    logic       start_lo;
    logic       lat_in;
    logic       rs_hi;
    logic       rs_ok;
    logic       cw;
    logic       ccw;
    logic       other_start;
    logic       run_req;
    logic       stop_any;
    logic       frz;
    logic       up_hi;
    logic       dn_hi;
    logic       ud_act;
    logic       ud_done;
    logic       wr;
    logic       clr_ev;
    logic [7:0] pmin_lo;

    // level and edge terms from the synchronised samples
    always_comb begin
        lvl      = s_r.sync2;
        rise     = s_r.sync2 & ~s_r.prev;
        fall     = ~s_r.sync2 & s_r.prev;
        coast    = |(~lvl & (sel(s_r.codes, C_COAST_LO) |
                   sel(s_r.codes, C_CLR_FREE_LO)));
        quick    = |(~lvl & sel(s_r.codes, C_QSTOP_LO));
        dc_req   = |(~lvl & sel(s_r.codes, C_DCB_LO));
        dc       = dc_req && s_r.cfg[CFG_DC_TIME] &&
                   s_r.cfg[CFG_DC_VOLT];
        stop_lo  = |(~lvl & (sel(s_r.codes, C_STOP_LO) |
                   sel(s_r.codes, C_PRE_STOP_LO)));
        start_hi = |(lvl & (sel(s_r.codes, C_START) |
                   sel(s_r.codes, C_RST_START)));
        start_lo = |(~lvl & sel(s_r.codes, C_START));
        lat_in   = |(lvl & sel(s_r.codes, C_LATCH));
        cw       = |(lvl & sel(s_r.codes, C_CW));
        ccw      = |(lvl & sel(s_r.codes, C_CCW));
        rs_hi    = |(lvl & sel(s_r.codes, C_REV_START)) &&
                   !s_r.cfg[CFG_CLOSED];
        other_start = start_hi || s_r.latch || cw || ccw;
        rs_ok    = rs_hi && !other_start;
        run_req  = start_hi || s_r.latch || rs_ok || cw || ccw;
        stop_any = coast || quick || dc || stop_lo;
        frz      = |(lvl & (sel(s_r.codes, C_FRZ_REF) |
                   sel(s_r.codes, C_FRZ_OUT)));
        up_hi    = |(lvl & sel(s_r.codes, C_UP));
        dn_hi    = |(lvl & sel(s_r.codes, C_DOWN));
        ud_act   = up_hi || dn_hi;
        ud_done  = (s_r.ud == UD_LOW) && !ud_act &&
                   (s_r.ud_cnt == CNT_W'(MIN_PULSE_CYCLES - 1));
        clr_ev   = |(rise & sel(s_r.codes, C_RESET)) ||
                   |(fall & sel(s_r.codes, C_CLR_FREE_LO)) ||
                   |(rise & sel(s_r.codes, C_RST_START));
        wr       = psel_in && penable_in && pwrite_in;
        pmin_lo  = paddr_in;
    end

    // next state: inputs, commands, timers and register file
    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync1 = term_in;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev  = s_r.sync2;

        // latched start: pulse must be held the full minimum time
        if (!lat_in) begin
            s_nxt.lat_cnt = '0;
        end else if (s_r.lat_cnt != CNT_W'(MIN_PULSE_CYCLES)) begin
            s_nxt.lat_cnt = s_r.lat_cnt + 20'h00001;
        end
        if (stop_lo) begin
            s_nxt.latch = 1'b0;
        end else if (lat_in && !stop_any &&
                     s_r.lat_cnt == CNT_W'(MIN_PULSE_CYCLES - 1)) begin
            s_nxt.latch = 1'b1;
        end

        // under freeze output only hard stops may end the run
        if (s_r.cmd.freeze_out && s_r.cmd.run) begin
            s_nxt.cmd.run = !(coast || quick || dc);
        end else begin
            s_nxt.cmd.run = run_req && !stop_any;
        end
        if (cw) begin
            s_nxt.cmd.reverse = 1'b0;
        end else if (ccw || rs_ok) begin
            s_nxt.cmd.reverse = 1'b1;
        end else begin
            s_nxt.cmd.reverse = |(lvl & sel(s_r.codes, C_REV)) &&
                                !s_r.cfg[CFG_CLOSED];
        end
        s_nxt.cmd.coast      = coast;
        s_nxt.cmd.quick_stop = quick;
        s_nxt.cmd.dc_brake   = dc;
        s_nxt.cmd.ramp_stop  = stop_lo || start_lo;
        s_nxt.cmd.inch       = |(lvl & sel(s_r.codes, C_INCH)) &&
                               !(coast || quick || dc);
        s_nxt.cmd.freeze_ref = |(lvl & sel(s_r.codes, C_FRZ_REF));
        s_nxt.cmd.freeze_out = |(lvl & sel(s_r.codes, C_FRZ_OUT));
        s_nxt.cmd.ramp2      = s_nxt.cmd.freeze_out && frz;
        s_nxt.cmd.alarm_clear = clr_ev && alarm_pending_in &&
                                !alarm_locked_in;
        if (rs_hi && other_start) begin
            s_nxt.conflict = 1'b1;
        end

        // up/down pulse qualifier: high time, then low time, then a step
        s_nxt.cmd.step_up     = 1'b0;
        s_nxt.cmd.step_down   = 1'b0;
        s_nxt.cmd.step_is_ref = s_r.cmd.freeze_ref;
        case (s_r.ud)
            UD_IDLE: begin
                if (ud_act) begin
                    s_nxt.ud     = UD_HIGH;
                    s_nxt.ud_cnt = 20'h00001;
                    s_nxt.ud_dn  = dn_hi;
                end
            end
            UD_HIGH: begin
                s_nxt.ud_dn = s_r.ud_dn || dn_hi;
                if (!ud_act) begin
                    s_nxt.ud_cnt = 20'h00001;
                    s_nxt.ud = (s_r.ud_cnt >= CNT_W'(MIN_PULSE_CYCLES)) ?
                               UD_LOW : UD_IDLE;
                end else if (s_r.ud_cnt != CNT_W'(MIN_PULSE_CYCLES)) begin
                    s_nxt.ud_cnt = s_r.ud_cnt + 20'h00001;
                end
            end
            UD_LOW: begin
                if (ud_act) begin
                    // break too short: start over as a fresh pulse
                    s_nxt.ud     = UD_HIGH;
                    s_nxt.ud_cnt = 20'h00001;
                    s_nxt.ud_dn  = dn_hi;
                end else if (ud_done) begin
                    s_nxt.ud = UD_IDLE;
                    if (frz) begin
                        s_nxt.cmd.step_down = s_r.ud_dn;
                        s_nxt.cmd.step_up   = !s_r.ud_dn;
                    end
                    if (frz && s_r.cmd.freeze_ref) begin
                        s_nxt.adj = s_r.ud_dn ? s_r.adj - 16'h0001 :
                                    s_r.adj + 16'h0001;
                    end
                end else begin
                    s_nxt.ud_cnt = s_r.ud_cnt + 20'h00001;
                end
            end
            default: begin
                s_nxt.ud = UD_IDLE;
            end
        endcase

        // register writes; a refused code keeps the old one
        if (wr && mapped(pmin_lo)) begin
            if (pmin_lo <= REG_CODE4) begin
                if (legal(int'(pmin_lo[4:2]), pwdata_in[5:0],
                          s_r.cfg[CFG_PULSE_OUT])) begin
                    s_nxt.codes[pmin_lo[4:2]] = pwdata_in[5:0];
                end else begin
                    s_nxt.reject = 1'b1;
                end
            end else if (pmin_lo == REG_CFG) begin
                s_nxt.cfg = pwdata_in[3:0];
            end else if (pmin_lo == REG_STAT) begin
                // write one clears, but a same-cycle conflict still wins
                if (pwdata_in[STAT_REJECT]) begin
                    s_nxt.reject = 1'b0;
                end
                if (pwdata_in[STAT_CONFLICT] && !(rs_hi && other_start)) begin
                    s_nxt.conflict = 1'b0;
                end
            end else begin
                s_nxt.adj = pwdata_in[15:0];
            end
        end

        // read data captured in the setup phase, zero for holes
        if (psel_in && !penable_in) begin
            s_nxt.prdata = 32'h00000000;
            if (mapped(pmin_lo) && pmin_lo <= REG_CODE4) begin
                s_nxt.prdata[5:0] = s_r.codes[pmin_lo[4:2]];
            end else if (mapped(pmin_lo) && pmin_lo == REG_CFG) begin
                s_nxt.prdata[3:0] = s_r.cfg;
            end else if (mapped(pmin_lo) && pmin_lo == REG_STAT) begin
                s_nxt.prdata[STAT_REJECT]   = s_r.reject;
                s_nxt.prdata[STAT_CONFLICT] = s_r.conflict;
                s_nxt.prdata[STAT_LATCH]    = s_r.latch;
                s_nxt.prdata[STAT_RUN]      = s_r.cmd.run;
                s_nxt.prdata[STAT_REV]      = s_r.cmd.reverse;
                s_nxt.prdata[STAT_TERM +: 5] = s_r.sync2;
            end else if (mapped(pmin_lo)) begin
                s_nxt.prdata[15:0] = s_r.adj;
            end
        end
    end

    // single state register; first sync stage feeds only the second
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r       <= '0;
            s_r.codes <= CODE_RST;
            s_r.cfg   <= CFG_RST;
            s_r.ud    <= UD_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs; the slave never inserts wait states
    assign pready_out     = 1'b1;
    assign pslverr_out    = psel_in && penable_in && !mapped(paddr_in);
    assign prdata_out     = s_r.prdata;
    assign cmd_out        = s_r.cmd;
    assign ref_adjust_out = s_r.adj;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_ud_low_done;
        (s_r.ud == UD_LOW) && !ud_act &&
        (s_r.ud_cnt == CNT_W'(MIN_PULSE_CYCLES - 1));
    endsequence

    a_coast_low_stops: assert property (
        coast |=> cmd_out.coast && !cmd_out.inch && !cmd_out.run)
        else $error("coast did not follow a low coast terminal");
    a_dc_needs_cfg: assert property (
        !(s_r.cfg[CFG_DC_TIME] && s_r.cfg[CFG_DC_VOLT]) |=>
        !cmd_out.dc_brake)
        else $error("dc brake issued with zero time or voltage");
    a_alarm_not_locked: assert property (
        cmd_out.alarm_clear |-> !$past(alarm_locked_in) && $past(clr_ev))
        else $error("alarm clear without edge or while locked");
    a_latch_full_hold: assert property (
        $rose(s_r.latch) |-> $past(s_r.lat_cnt) ==
        CNT_W'(MIN_PULSE_CYCLES - 1))
        else $error("latch set before the minimum pulse time");
    a_step_needs_freeze: assert property (
        (cmd_out.step_up || cmd_out.step_down) |-> $past(frz))
        else $error("speed step without a freeze function");
    a_step_after_break: assert property (
        s_ud_low_done ##0 frz |=> (cmd_out.step_up != cmd_out.step_down)
        ##1 !cmd_out.step_up && !cmd_out.step_down)
        else $error("qualified pulse did not give exactly one step");
    a_stop_low_halts: assert property (
        stop_lo && !s_r.cmd.freeze_out |=> !cmd_out.run [*1])
        else $error("run stayed on with stop inverse low");
    a_code_refused: assert property (
        wr && pmin_lo <= REG_CODE4 && mapped(pmin_lo) &&
        !legal(int'(pmin_lo[4:2]), pwdata_in[5:0], s_r.cfg[CFG_PULSE_OUT])
        |=> $stable(s_r.codes) && s_r.reject)
        else $error("illegal code was stored or not flagged");
    a_pulse_out_block: assert property (
        wr && pmin_lo == 8'h0c && s_r.cfg[CFG_PULSE_OUT] &&
        (pwdata_in[5:0] == C_PULSE_REF || pwdata_in[5:0] == C_PULSE_FB)
        |=> s_r.codes[3] == $past(s_r.codes[3]))
        else $error("pulse code taken while output is pulse");
    a_inch_blocked: assert property (
        cmd_out.inch |-> !cmd_out.coast && !cmd_out.quick_stop &&
        !cmd_out.dc_brake)
        else $error("inching active during a stop function");

endmodule : ddid_top
`default_nettype wire

// File: verification/ddid_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural switch bank standing at the terminals; no contact bounce
module ddid_switch_model (
    input  wire logic       clk_in,
    input  wire logic [4:0] level_in,
    output logic      [4:0] term_out
);
    logic [4:0] pulse_r = 5'h00;
    // a pulse is held high n cycles, then low n cycles
    task pulse(input int b, input int n);
        @(posedge clk_in);
        pulse_r[b] <= 1'b1;
        repeat (n) @(posedge clk_in);
        pulse_r[b] <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask : pulse
    // levels change only just after an edge, never mid-cycle
    assign term_out = level_in | pulse_r;
endmodule : ddid_switch_model
`default_nettype wire

// File: verification/test_drive_digital_input_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module test_drive_digital_input_decoder;
    import ddid_pkg::*;
    localparam int   MIN = 20;
    localparam logic R   = 1'b0;
    localparam logic W   = 1'b1;
    logic         clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic         pwrite = 1'b0, pend = 1'b0, locked = 1'b0, clr_seen = 1'b0;
    logic         pready, pslverr;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata;
    logic [4:0]   level = 5'h04, term;
    logic [15:0]  adj;
    logic [33:0]  note;
    logic [33:0]  notes[$];
    ddid_cmd_type cmd, held;
    int           fail_count = 0, cmp_count = 0, seed, i, ups = 0, downs = 0;

    // free-running 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    ddid_top #(.MIN_PULSE_CYCLES(MIN)) ddid_top_i (.clk_in(clk),
        .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .term_in(term), .alarm_pending_in(pend), .alarm_locked_in(locked),
        .cmd_out(cmd), .ref_adjust_out(adj));
    ddid_switch_model ddid_switch_model_i (.clk_in(clk), .level_in(level),
        .term_out(term));

    task check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task cmdchk(input string what, input logic seen, exp);
        check(what, {31'h0, seen}, {31'h0, exp});
    endtask : cmdchk
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // one apb transfer; the note holds direction, error and read data
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        notes.push_back({w, err, d});
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // takes the oldest note at each completed transfer; catches clear pulses
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            if (!note[33]) check("prdata", prdata, note[31:0]);
        end
        if (cmd.alarm_clear === 1'b1) clr_seen <= 1'b1;
        if (cmd.step_up === 1'b1) ups++;
        if (cmd.step_down === 1'b1) downs++;
    end

    // watchdog: the whole run needs only a few hundred cycles
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end

    // main sequence
    initial begin
        seed = $urandom(10510);
        tick(12);
        rstn <= 1'b1;
        for (i = 0; i < 5; i++) apb(R, 8'(i * 4), 32'(CODE_RST[i]), 1'b0);
        apb(R, REG_CFG, 32'h0, 1'b0);
        apb(R, 8'h20, 32'h0, 1'b1);
        $display("test reset values done");
        // codes a terminal cannot take are refused and flagged
        apb(W, REG_CODE0, 32'(C_PULSE_REF), 1'b0);
        apb(R, REG_CODE0, 32'(C_START), 1'b0);
        apb(R, REG_STAT, 32'h401, 1'b0);
        apb(W, REG_STAT, 32'h1, 1'b0);
        apb(W, REG_CFG, 32'h1, 1'b0);
        apb(W, 8'h0c, 32'(C_PULSE_FB), 1'b0);
        apb(R, 8'h0c, 32'(C_INCH), 1'b0);
        apb(W, REG_CODE4, 32'(C_PULSE_IN), 1'b0);
        apb(R, REG_CODE4, 32'(C_PULSE_IN), 1'b0);
        apb(W, REG_CODE4, 32'h0, 1'b0);
        $display("test code refusal done");
        // start code follows the level
        level[0] <= 1'b1;
        tick(4);
        cmdchk("run", cmd.run, 1'b1);
        level[0] <= 1'b0;
        tick(4);
        cmdchk("run", cmd.run, 1'b0);
        cmdchk("ramp_stop", cmd.ramp_stop, 1'b1);
        // freewheel code: coast while low, clear on the falling edge
        pend <= 1'b1;
        level[2] <= 1'b0;
        tick(5); // the clear pulse is noted one edge after it shows
        cmdchk("coast", cmd.coast, 1'b1);
        cmdchk("clear", clr_seen, 1'b1);
        level[2] <= 1'b1;
        locked <= 1'b1;
        tick(4);
        clr_seen <= 1'b0;
        level[2] <= 1'b0;
        tick(5);
        cmdchk("locked clear", clr_seen, 1'b0);
        level[2] <= 1'b1;
        locked <= 1'b0;
        // coast on terminal 1 blocks inching until released
        apb(W, 8'h04, 32'(C_COAST_LO), 1'b0);
        level[3] <= 1'b1;
        tick(4);
        cmdchk("coast", cmd.coast, 1'b1);
        cmdchk("inch", cmd.inch, 1'b0);
        level[1] <= 1'b1;
        tick(4);
        cmdchk("inch", cmd.inch, 1'b1);
        // dc brake acts only with time and voltage both set
        apb(W, 8'h04, 32'(C_DCB_LO), 1'b0);
        level[1] <= 1'b0;
        tick(4);
        cmdchk("dc", cmd.dc_brake, 1'b0);
        apb(W, REG_CFG, 32'h0c, 1'b0);
        tick(4);
        cmdchk("dc", cmd.dc_brake, 1'b1);
        level[1] <= 1'b1;
        tick(4);
        // quick-stop inverse on terminal 1
        apb(W, 8'h04, 32'(C_QSTOP_LO), 1'b0);
        level[1] <= 1'b0;
        tick(4);
        cmdchk("quick", cmd.quick_stop, 1'b1);
        level[1] <= 1'b1;
        tick(4);
        $display("test stop codes done");
        // terminal 4 has no function: random levels change nothing
        held = cmd;
        for (i = 0; i < 16; i++) begin
            level[4] <= 1'($urandom());
            @(posedge clk);
        end
        level[4] <= 1'b0;
        tick(4);
        check("cmd", 32'(cmd), 32'(held));
        // latched start, too short a pulse, release by stop inverse
        apb(W, REG_CODE0, 32'(C_STOP_LO), 1'b0);
        level[0] <= 1'b1;
        level[1] <= 1'b0;
        apb(W, 8'h04, 32'(C_LATCH), 1'b0);
        ddid_switch_model_i.pulse(1, MIN - 4);
        cmdchk("short latch", cmd.run, 1'b0);
        ddid_switch_model_i.pulse(1, MIN + 2);
        cmdchk("latch", cmd.run, 1'b1);
        level[0] <= 1'b0;
        tick(4);
        level[0] <= 1'b1;
        tick(4);
        cmdchk("unlatch", cmd.run, 1'b0);
        // reversing flips direction only, not in closed loop; ccw runs
        apb(W, 8'h04, 32'(C_REV), 1'b0);
        level[1] <= 1'b1;
        tick(4);
        cmdchk("reverse", cmd.reverse, 1'b1);
        cmdchk("rev run", cmd.run, 1'b0);
        apb(W, REG_CFG, 32'h0e, 1'b0);
        tick(4);
        cmdchk("closed rev", cmd.reverse, 1'b0);
        apb(W, 8'h04, 32'(C_CCW), 1'b0);
        tick(4);
        cmdchk("ccw", cmd.reverse, 1'b1);
        cmdchk("ccw run", cmd.run, 1'b1);
        level[1] <= 1'b0;
        apb(W, REG_CFG, 32'h0c, 1'b0);
        // frozen reference stepped once up, twice down
        apb(W, 8'h0c, 32'(C_FRZ_REF), 1'b0);
        apb(W, REG_CODE4, 32'(C_UP), 1'b0);
        ddid_switch_model_i.pulse(4, MIN + 4);
        apb(R, REG_ADJ, 32'h1, 1'b0);
        check("adjust", 32'(adj), 32'h1);
        cmdchk("freeze ref", cmd.freeze_ref, 1'b1);
        apb(W, REG_CODE4, 32'(C_DOWN), 1'b0);
        ddid_switch_model_i.pulse(4, MIN + 4);
        ddid_switch_model_i.pulse(4, MIN + 4);
        apb(R, REG_ADJ, 32'hffff, 1'b0);
        check("ups", 32'(ups), 32'h1);
        check("downs", 32'(downs), 32'h2);
        $display("test latch and freeze done");
        report_and_stop();
    end
endmodule : test_drive_digital_input_decoder
`default_nettype wire
